// file: hw/strap_cfg_pkg.sv
/*
  Constants for the strap sampler: interface codes, pin indices,
  register 0x56 field positions and reset values.
  Assumes nothing of its surroundings.
*/
package strap_cfg_pkg;
  localparam int NUM_STRAPS = 7;
  // Strap vector bit positions
  localparam int IDX_IFACE_LO = 0;
  localparam int IDX_IFACE_HI = 1;
  localparam int IDX_ROLE = 2;
  localparam int IDX_REFCLK = 3;
  localparam int IDX_PLL = 4;
  localparam int IDX_SPEED = 5;
  localparam int IDX_BUS = 6;
  // Uplink interface codes
  localparam logic [1:0] IFACE_MII = 2'h0;
  localparam logic [1:0] IFACE_RMII = 2'h1;
  localparam logic [1:0] IFACE_RSVD = 2'h2;
  localparam logic [1:0] IFACE_RGMII = 2'h3;
  // Configuration register 0x56 and its fields
  localparam logic [7:0] CFG_REG_ADDR = 8'h56;
  localparam int CFG_CLK_SEL_BIT = 7;
  localparam int CFG_DELAY_LO = 3;
  localparam int CFG_DELAY_HI = 4;
  localparam int CFG_SPEED_BIT = 6;
  // Reset values of the latched configuration (pull defaults)
  localparam logic [6:0] STRAP_RESET = 7'h3f;
  localparam logic [1:0] DELAY_RESET = 2'h0;
endpackage : strap_cfg_pkg

// file: hw/strap_pin_cell.sv
/*
  One strap pin: sampled while reset is active, drives its functional
  output once released.
  Assumes synchronous active-low reset and a pull on the board.
*/
`timescale 1ns/1ps
`default_nettype none
module strap_pin_cell #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  input wire logic func_i,
  output logic sample_o,
  output logic pin_o,
  output logic pin_oe_o
);
  // Sample while reset held, freeze on release
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sample_o <= pin_i; // see (R1)
    end
  end

  // Input with pull during reset, driven output afterwards
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_oe_o <= 1'b0; // see (R12)
      // Undriven pin in reset shows its internal pull level
      pin_o <= RESET_LEVEL; // see (R13)
    end else begin
      pin_oe_o <= 1'b1;
      pin_o <= func_i;
    end
  end

  AST_PIN_HIZ_IN_RESET: assert property (@(posedge clk_i)
    $past(reset_n_i) == 1'b0 |-> !pin_oe_o) // see (R12)
    else $error("strap pin driven during reset");
  AST_SAMPLE_HELD: assert property (@(posedge clk_i)
    reset_n_i && $past(reset_n_i) |-> $stable(sample_o)) // see (R18)
    else $error("strap sample changed outside reset");
  AST_SAMPLE_TRACKS: assert property (@(posedge clk_i)
    !$past(reset_n_i) |-> sample_o == $past(pin_i)) // see (R1)
    else $error("strap sample missed the pin level");
endmodule : strap_pin_cell
`default_nettype wire

// file: hw/switch_strap_config_sampler.sv
/*
  Strap sampler for the uplink port of a four-port switch. Samples the
  strap pins during reset, latches them on release and derives the
  uplink configuration, with register 0x56 overrides from management.
  Assumes board pulls on every strap and a single 10 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (R1) Sample every strap during reset
// (R2) Two straps pick MII, RMII or RGMII
// (R3) MII: high is MAC, low is PHY
// (R4) RMII high: drive 50 MHz clock out
// (R5) RMII low: expect external 50 MHz clock
// (R6) RMII clock source from strap or 0x56[7]
// (R7) High strap enables 25 MHz reference output
// (R8) RMII normal: PLL source crystal or external
// (R9) RGMII speed strap, register may override
// (R10) Low selects SPI, high selects MDIO
// (R11) Delay bits 4:3 writable by SPI only
// (R12) Pull-up straps: input in reset, output after
// (R13) Bus strap: pull-down input, output after
// (R14) Board fits external pull on bus strap
// (R15) Three-port or four-port with uplink
// (R16) Host manages over the selected bus
// (R17) Host clocks serial bus within limits
// (R18) Latched straps hold until next reset
module switch_strap_config_sampler #(
  parameter int NUM_STRAPS = strap_cfg_pkg::NUM_STRAPS
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [1:0] UPLINK_IFACE_SELECT_STRAPS_I,
  input wire logic UPLINK_ROLE_CLOCK_STRAP_I,
  input wire logic REFCLK_OUT_ENABLE_STRAP_I,
  input wire logic PLL_SOURCE_STRAP_I,
  input wire logic UPLINK_SPEED_STRAP_I,
  input wire logic SERIAL_OUT_BUS_SELECT_STRAP_I,
  input wire logic [NUM_STRAPS-1:0] STRAP_FUNC_I,
  input wire logic UPLINK_ENABLE_I,
  input wire logic CFG_WR_I,
  input wire logic CFG_WR_FROM_SPI_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [7:0] CFG_WDATA_I,
  output logic [NUM_STRAPS-1:0] STRAP_PIN_O,
  output logic [NUM_STRAPS-1:0] STRAP_PIN_OE_O,
  output logic [1:0] UPLINK_IFACE_O,
  output logic UPLINK_IFACE_RESERVED_O,
  output logic UPLINK_ACTIVE_O,
  output logic MII_MAC_MODE_O,
  output logic RMII_CLOCK_MODE_O,
  output logic RMII_EXT_REF_CLOCK_OUTPUT,
  output logic REF_CLOCK_OUTPUT_EN_O,
  output logic PLL_FROM_EXT_CLK_O,
  output logic RGMII_GIGABIT_O,
  output logic MGMT_MDIO_SEL_O,
  output logic [1:0] RGMII_DELAY_O,
  output logic CFG_WR_REJECTED_O
);
  // Pin order and decode are fixed to the seven straps
  if (NUM_STRAPS != strap_cfg_pkg::NUM_STRAPS) begin : g_bad_strap_count
    $error("NUM_STRAPS must match the strap set");
  end

  logic [NUM_STRAPS-1:0] pin_in;
  logic [NUM_STRAPS-1:0] smp;
  logic rst_d_ff;
  logic clk_ovr_ff;
  logic clk_ovr_val_ff;
  logic spd_ovr_ff;
  logic spd_ovr_val_ff;
  logic [1:0] delay_ff;
  logic reg_hit;
  logic nxt_is_rmii;
  logic nxt_clk_mode;
  logic nxt_gig;

  assign pin_in = {SERIAL_OUT_BUS_SELECT_STRAP_I, UPLINK_SPEED_STRAP_I,
    PLL_SOURCE_STRAP_I, REFCLK_OUT_ENABLE_STRAP_I,
    UPLINK_ROLE_CLOCK_STRAP_I, UPLINK_IFACE_SELECT_STRAPS_I};

  genvar g;
  generate
    for (g = 0; g < NUM_STRAPS; g++) begin : g_pin
      // Bus strap has a pull-down, others pull-up
      strap_pin_cell #(
        .RESET_LEVEL(g != strap_cfg_pkg::IDX_BUS) // see (R13)
      ) u_cell (
        .clk_i(CORE_CLK_I),
        .reset_n_i(RESET_N_I),
        .pin_i(pin_in[g]),
        .func_i(STRAP_FUNC_I[g]),
        .sample_o(smp[g]),
        .pin_o(STRAP_PIN_O[g]),
        .pin_oe_o(STRAP_PIN_OE_O[g])
      );
    end
  endgenerate

  assign reg_hit = CFG_WR_I && CFG_ADDR_I == strap_cfg_pkg::CFG_REG_ADDR;

  // Register 0x56 overrides, cleared by every reset
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      clk_ovr_ff <= 1'b0;
      clk_ovr_val_ff <= 1'b0;
      spd_ovr_ff <= 1'b0;
      spd_ovr_val_ff <= 1'b0;
    end else if (reg_hit) begin
      clk_ovr_ff <= 1'b1;
      clk_ovr_val_ff <= CFG_WDATA_I[strap_cfg_pkg::CFG_CLK_SEL_BIT]; // see (R6)
      spd_ovr_ff <= 1'b1;
      spd_ovr_val_ff <= CFG_WDATA_I[strap_cfg_pkg::CFG_SPEED_BIT]; // see (R9)
    end
  end

  // Delay field only takes SPI writes
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      delay_ff <= strap_cfg_pkg::DELAY_RESET;
      CFG_WR_REJECTED_O <= 1'b0;
    end else begin
      CFG_WR_REJECTED_O <= reg_hit && !CFG_WR_FROM_SPI_I; // see (R11)
      if (reg_hit && CFG_WR_FROM_SPI_I) begin
        delay_ff <= CFG_WDATA_I[strap_cfg_pkg::CFG_DELAY_HI:
                                strap_cfg_pkg::CFG_DELAY_LO]; // see (R11)
      end
    end
  end

  assign nxt_is_rmii = smp[strap_cfg_pkg::IDX_IFACE_HI:
                           strap_cfg_pkg::IDX_IFACE_LO] ==
                       strap_cfg_pkg::IFACE_RMII;
  assign nxt_clk_mode = clk_ovr_ff ? clk_ovr_val_ff
                      : smp[strap_cfg_pkg::IDX_ROLE]; // see (R6)
  assign nxt_gig = spd_ovr_ff ? spd_ovr_val_ff
                 : smp[strap_cfg_pkg::IDX_SPEED]; // see (R9)

  // Outputs settle one edge after the release of reset
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      rst_d_ff <= 1'b0;
      UPLINK_IFACE_O <= strap_cfg_pkg::IFACE_RGMII;
      UPLINK_IFACE_RESERVED_O <= 1'b0;
      UPLINK_ACTIVE_O <= 1'b0;
      MII_MAC_MODE_O <= 1'b0;
      RMII_CLOCK_MODE_O <= 1'b0;
      RMII_EXT_REF_CLOCK_OUTPUT <= 1'b0;
      REF_CLOCK_OUTPUT_EN_O <= 1'b1;
      PLL_FROM_EXT_CLK_O <= 1'b0;
      RGMII_GIGABIT_O <= 1'b1;
      MGMT_MDIO_SEL_O <= 1'b0;
      RGMII_DELAY_O <= strap_cfg_pkg::DELAY_RESET;
    end else begin
      rst_d_ff <= 1'b1;
      UPLINK_IFACE_O <= smp[strap_cfg_pkg::IDX_IFACE_HI:
                            strap_cfg_pkg::IDX_IFACE_LO]; // see (R2)
      UPLINK_IFACE_RESERVED_O <= smp[strap_cfg_pkg::IDX_IFACE_HI:
                                     strap_cfg_pkg::IDX_IFACE_LO] ==
                                 strap_cfg_pkg::IFACE_RSVD; // see (R2)
      UPLINK_ACTIVE_O <= UPLINK_ENABLE_I; // see (R15)
      MII_MAC_MODE_O <= smp[strap_cfg_pkg::IDX_IFACE_HI:
                            strap_cfg_pkg::IDX_IFACE_LO] ==
                        strap_cfg_pkg::IFACE_MII &&
                        smp[strap_cfg_pkg::IDX_ROLE]; // see (R3)
      RMII_CLOCK_MODE_O <= nxt_is_rmii && nxt_clk_mode; // see (R4)
      RMII_EXT_REF_CLOCK_OUTPUT <= nxt_is_rmii && !nxt_clk_mode; // see (R5)
      REF_CLOCK_OUTPUT_EN_O <= smp[strap_cfg_pkg::IDX_REFCLK]; // see (R7)
      PLL_FROM_EXT_CLK_O <= nxt_is_rmii && !nxt_clk_mode &&
                            !smp[strap_cfg_pkg::IDX_PLL]; // see (R8)
      RGMII_GIGABIT_O <= nxt_gig; // see (R9)
      MGMT_MDIO_SEL_O <= smp[strap_cfg_pkg::IDX_BUS]; // see (R10) (R16)
      RGMII_DELAY_O <= delay_ff;
    end
  end

  AST_MODE_EXCLUSIVE: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    !(RMII_CLOCK_MODE_O && RMII_EXT_REF_CLOCK_OUTPUT)) // see (R4)
    else $error("RMII clock and normal mode both set");
  AST_EXT_NEEDS_RMII: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    RMII_EXT_REF_CLOCK_OUTPUT |-> UPLINK_IFACE_O == strap_cfg_pkg::IFACE_RMII)
    // see (R5)
    else $error("external refclk outside RMII");
  AST_PLL_NORMAL_ONLY: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    PLL_FROM_EXT_CLK_O |-> RMII_EXT_REF_CLOCK_OUTPUT) // see (R8)
    else $error("PLL on external clock outside RMII normal");
  AST_MAC_NEEDS_MII: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    MII_MAC_MODE_O |-> UPLINK_IFACE_O == strap_cfg_pkg::IFACE_MII) // see (R3)
    else $error("MAC role outside MII");
  AST_MDIO_NO_DELAY: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    reg_hit && !CFG_WR_FROM_SPI_I |=> $stable(delay_ff)) // see (R11)
    else $error("delay changed by MDIO write");
  AST_REJECT_FLAG: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    reg_hit && !CFG_WR_FROM_SPI_I |=> CFG_WR_REJECTED_O) // see (R11)
    else $error("MDIO delay write not flagged");
  AST_IFACE_FROM_STRAP: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    rst_d_ff |-> UPLINK_IFACE_O == $past(smp[1:0])) // see (R2)
    else $error("interface code differs from strap");
  AST_BUS_FROM_STRAP: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    rst_d_ff |-> MGMT_MDIO_SEL_O == $past(smp[strap_cfg_pkg::IDX_BUS]))
    // see (R10)
    else $error("bus select differs from strap");
  AST_REFCLK_HELD: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    rst_d_ff && $past(rst_d_ff) |-> $stable(REF_CLOCK_OUTPUT_EN_O))
    // see (R7) (R18)
    else $error("refclk enable moved after reset");
  AST_ACTIVE_FOLLOWS: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I)
    rst_d_ff |-> UPLINK_ACTIVE_O == $past(UPLINK_ENABLE_I)) // see (R15)
    else $error("uplink active differs from enable");
endmodule : switch_strap_config_sampler
`default_nettype wire

// file: test/strap_pull_board.sv
/*
  Board-side strap resistors: each strap wire sits at its pull level
  unless the sampler drives it.
  Assumes seven straps in the bit order of the design package.
*/
`timescale 1ns/1ps
`default_nettype none
module strap_pull_board (
  input wire logic [6:0] pull_up_i,
  input wire logic [6:0] pin_i,
  input wire logic [6:0] pin_oe_i,
  output logic [6:0] wire_o
);
  // External resistor on every strap, bus strap included
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      wire_o[i] = pin_oe_i[i] ? pin_i[i] : pull_up_i[i];
    end
  end
endmodule : strap_pull_board
`default_nettype wire

// file: test/switch_strap_config_sampler_test.sv
/*
  Self-checking bench for the strap sampler: strap decode, pin turn-
  around and register 0x56 overrides.
  Assumes the board pull model and a 10 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module switch_strap_config_sampler_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] pulls = 7'h3f;
  logic [6:0] func = 7'h55;
  logic en = 1'b1;
  logic wr = 1'b0;
  logic spi = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [6:0] lvl, pin, oe;
  logic [1:0] iface, dly;
  logic rsvd, act, mac, ckm, ext, ref_en, pll_ext, gig, mdio, rej;
  int error_cnt = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  strap_pull_board i_strap_pull_board (.pull_up_i(pulls), .pin_i(pin),
    .pin_oe_i(oe), .wire_o(lvl));
  switch_strap_config_sampler i_switch_strap_config_sampler (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .UPLINK_IFACE_SELECT_STRAPS_I(lvl[1:0]),
    .UPLINK_ROLE_CLOCK_STRAP_I(lvl[2]), .REFCLK_OUT_ENABLE_STRAP_I(lvl[3]),
    .PLL_SOURCE_STRAP_I(lvl[4]), .UPLINK_SPEED_STRAP_I(lvl[5]),
    .SERIAL_OUT_BUS_SELECT_STRAP_I(lvl[6]), .STRAP_FUNC_I(func),
    .UPLINK_ENABLE_I(en), .CFG_WR_I(wr), .CFG_WR_FROM_SPI_I(spi),
    .CFG_ADDR_I(addr), .CFG_WDATA_I(wdata), .STRAP_PIN_O(pin),
    .STRAP_PIN_OE_O(oe), .UPLINK_IFACE_O(iface),
    .UPLINK_IFACE_RESERVED_O(rsvd), .UPLINK_ACTIVE_O(act),
    .MII_MAC_MODE_O(mac), .RMII_CLOCK_MODE_O(ckm), .RMII_EXT_REF_CLOCK_OUTPUT(ext),
    .REF_CLOCK_OUTPUT_EN_O(ref_en), .PLL_FROM_EXT_CLK_O(pll_ext),
    .RGMII_GIGABIT_O(gig), .MGMT_MDIO_SEL_O(mdio), .RGMII_DELAY_O(dly),
    .CFG_WR_REJECTED_O(rej));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_vec(input logic [6:0] got, input logic [6:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: vec got %h exp %h", $time, got, exp);
    end
  endtask : check_vec

  // Reset with given pulls, release, check decode and pin turnaround
  task automatic boot(input logic [6:0] p, input int hold);
    logic r;
    logic rm;
    logic [1:0] f;
    f = p[1:0];
    r = p[2];
    rm = f == strap_cfg_pkg::IFACE_RMII;
    pulls = p;
    rst_n = 1'b0;
    tick(hold);
    check_vec(oe, 7'h00);
    check_vec(pin, strap_cfg_pkg::STRAP_RESET);
    check_vec({5'h00, iface}, {5'h00, strap_cfg_pkg::IFACE_RGMII});
    rst_n = 1'b1;
    tick(1);
    check_vec({5'h00, iface}, {5'h00, f});
    tick(1);
    check_vec(oe, 7'h7f);
    check_vec(pin, func);
    check_vec({5'h00, iface}, {5'h00, f});
    check_bit(rsvd, f == strap_cfg_pkg::IFACE_RSVD);
    check_bit(mac, f == strap_cfg_pkg::IFACE_MII && r);
    check_bit(ckm, rm && r);
    check_bit(ext, rm && !r);
    check_bit(ref_en, p[3]);
    check_bit(pll_ext, rm && !r && !p[4]);
    check_bit(gig, p[5]);
    check_bit(mdio, p[6]);
    check_bit(act, en);
  endtask : boot

  // Host write, at most one per core cycle, slow against the serial clock
  task automatic cfg_write(input logic s, input logic [7:0] a,
                           input logic [7:0] d, input logic exp_rej);
    spi = s;
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    check_bit(rej, exp_rej);
    tick(1);
    check_bit(rej, 1'b0);
  endtask : cfg_write

  // SPI and MDIO writes to 0x56, an ignored address, then a reset
  task automatic overrides;
    boot(7'h01, 3);
    cfg_write(1'b1, strap_cfg_pkg::CFG_REG_ADDR, 8'h90, 1'b0);
    check_bit(ckm, 1'b1);
    check_bit(ext, 1'b0);
    check_bit(pll_ext, 1'b0);
    check_vec({5'h00, dly}, 7'h02);
    check_bit(gig, 1'b0);
    cfg_write(1'b0, strap_cfg_pkg::CFG_REG_ADDR, 8'h48, 1'b1);
    check_vec({5'h00, dly}, 7'h02);
    check_bit(gig, 1'b1);
    check_bit(ckm, 1'b0);
    check_bit(ext, 1'b1);
    check_bit(pll_ext, 1'b1);
    cfg_write(1'b0, 8'h57, 8'h80, 1'b0);
    check_bit(ckm, 1'b0);
    check_vec({5'h00, iface}, 7'h01);
    cfg_write(1'b1, strap_cfg_pkg::CFG_REG_ADDR, 8'h80, 1'b0);
    check_bit(ckm, 1'b1);
    // Reset drops the overrides and the delay setting
    boot(7'h01, 3);
    check_vec({5'h00, dly}, {5'h00, strap_cfg_pkg::DELAY_RESET});
  endtask : overrides

  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  logic [6:0] pats [8] = '{7'h7f, 7'h00, 7'h04, 7'h01, 7'h11, 7'h05,
                           7'h02, 7'h3f};
  initial begin
    for (int i = 0; i < 8; i++) begin
      en = i[0];
      boot(pats[i], (i == 0) ? 16 : 3);
    end
    overrides;
    final_report;
  end

  // Whole run needs well under 200 cycles
  initial begin
    #200000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report;
  end
endmodule : switch_strap_config_sampler_test
`default_nettype wire
